// file: rtl/adc_acquisition_sequencer.sv
// sequencer for acquisition, conversion and result reads
`timescale 1ns/10ps
module adc_acquisition_sequencer (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // host bus strobes
  input  adc_seq_pkg::bus_ctl_t      bus_ctl,
  input  wire logic [7:0]            data_in,
  output logic      [11:0]           data_out,
  output logic                       data_oe,
  // conversion clock tick and analog core
  input  wire logic                  conv_tick,
  input  wire logic [11:0]           sar_result,
  // status
  output logic                       done_n,
  output logic                       track,
  output logic                       converting,
  output logic      [7:0]            cfg
);
  //----------------------------------------
  // strobe edges
  //----------------------------------------
  logic wr_q;
  logic rd_q;
  logic wr_rise;
  logic rd_fall;
  assign wr_rise = bus_ctl.wr_n & ~wr_q & ~bus_ctl.cs_n;
  assign rd_fall = ~bus_ctl.rd_n & rd_q & ~bus_ctl.cs_n;

  //----------------------------------------
  // sequencer
  //----------------------------------------
  adc_seq_pkg::seq_state_t state;
  adc_seq_pkg::seq_state_t next_state;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [7:0]  next_cfg;
  logic        next_done_n;
  logic        next_oe;
  logic        load;
  logic        next_track;
  logic        next_conv;
  logic [11:0] held;
  logic        mode_bit;
  assign mode_bit = data_in[adc_seq_pkg::ACQ_MODE_POS];

  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_cfg    = cfg;
    next_done_n = done_n;
    load        = 1'b0;
    if (wr_rise) begin
      next_done_n = 1'b1;
      next_cnt    = 4'h0;
      if (state == adc_seq_pkg::ST_EXT) begin
        // only power bits take the new byte; a terminating write also clears the mode bit
        next_cfg = (cfg & adc_seq_pkg::CFG_KEEP_MASK) |
                   (data_in & ~adc_seq_pkg::CFG_KEEP_MASK);
        next_state = mode_bit ? adc_seq_pkg::ST_EXT : adc_seq_pkg::ST_CONV;
        if (!mode_bit) begin
          next_cfg[adc_seq_pkg::ACQ_MODE_POS] = 1'b0;
        end
      end else begin
        next_cfg   = data_in;
        next_state = mode_bit ? adc_seq_pkg::ST_EXT : adc_seq_pkg::ST_ACQ;
      end
    end else begin
      unique case (state)
        adc_seq_pkg::ST_IDLE: begin
        end
        adc_seq_pkg::ST_EXT: begin
        end
        adc_seq_pkg::ST_ACQ: begin
          if (conv_tick) begin
            if (cnt == adc_seq_pkg::ACQ_CYCLES - 4'h1) begin
              next_cnt   = 4'h0;
              next_state = adc_seq_pkg::ST_CONV;
            end else begin
              next_cnt = cnt + 4'h1;
            end
          end
        end
        adc_seq_pkg::ST_CONV: begin
          if (conv_tick) begin
            if (cnt == adc_seq_pkg::CONV_CYCLES - 4'h1) begin
              next_cnt    = 4'h0;
              next_state  = adc_seq_pkg::ST_IDLE;
              load        = 1'b1;
              next_done_n = 1'b0;
            end else begin
              next_cnt = cnt + 4'h1;
            end
          end
        end
      endcase
      if (rd_fall && !load) begin
        next_done_n = 1'b1;
      end
    end
    next_oe    = ~bus_ctl.cs_n & ~bus_ctl.rd_n;
    next_track = (next_state == adc_seq_pkg::ST_ACQ) || (next_state == adc_seq_pkg::ST_EXT);
    next_conv  = (next_state == adc_seq_pkg::ST_CONV);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= adc_seq_pkg::ST_IDLE;
      cnt        <= 4'h0;
      cfg        <= adc_seq_pkg::CFG_RESET;
      done_n     <= 1'b1;
      wr_q       <= 1'b1;
      rd_q       <= 1'b1;
      data_oe    <= 1'b0;
      track      <= 1'b0;
      converting <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      cfg        <= next_cfg;
      done_n     <= next_done_n;
      wr_q       <= bus_ctl.wr_n;
      rd_q       <= bus_ctl.rd_n;
      data_oe    <= next_oe;
      track      <= next_track;
      converting <= next_conv;
    end
  end

  //----------------------------------------
  // result storage and read data
  //----------------------------------------
  adc_result_reg u_result (
    .clk       (clk),
    .rst       (rst),
    .load      (load),
    .load_data (sar_result),
    .held      (held)
  );
  always_ff @(posedge clk) begin
    if (rst) begin
      data_out <= adc_seq_pkg::RESULT_RESET;
    end else begin
      data_out <= held;
    end
  end

  //----------------------------------------
  // checks
  //----------------------------------------
  chk_oe_select: assert property (@(posedge clk) disable iff (rst)
    bus_ctl.cs_n |=> !data_oe) else $error("bus driven while deselected");
  chk_read_drive: assert property (@(posedge clk) disable iff (rst)
    (!bus_ctl.cs_n && !bus_ctl.rd_n) |=> data_oe) else $error("read not driven");
  chk_done_low: assert property (@(posedge clk) disable iff (rst)
    load |=> !done_n) else $error("done flag not low");
  chk_write_clear: assert property (@(posedge clk) disable iff (rst)
    wr_rise |=> done_n) else $error("done not cleared by write");
  chk_read_clear: assert property (@(posedge clk) disable iff (rst)
    (rd_fall && !load && !wr_rise) |=> done_n) else $error("done not cleared by read");
  chk_int_acq: assert property (@(posedge clk) disable iff (rst)
    (wr_rise && !mode_bit && state != adc_seq_pkg::ST_EXT) |=> track)
    else $error("acquisition not started");
  chk_ext_hold: assert property (@(posedge clk) disable iff (rst)
    (wr_rise && mode_bit) |=> (track && !converting)) else $error("ext track lost");
  chk_ext_end: assert property (@(posedge clk) disable iff (rst)
    (wr_rise && !mode_bit && state == adc_seq_pkg::ST_EXT) |=> converting)
    else $error("ext conversion not started");
  chk_abort_conv: assert property (@(posedge clk) disable iff (rst)
    (wr_rise && converting && !mode_bit) |=> (track && !converting))
    else $error("conversion not aborted");
  chk_result_load: assert property (@(posedge clk) disable iff (rst)
    load |=> ##1 (data_out == $past(sar_result, 2))) else $error("result not presented");
  chk_conv_len: assert property (@(posedge clk) disable iff (rst)
    (state == adc_seq_pkg::ST_CONV && conv_tick && !wr_rise &&
     cnt == (adc_seq_pkg::CONV_CYCLES - 4'h1)) |=> !converting)
    else $error("conversion length wrong");
  cov_done: cover property (@(posedge clk) disable iff (rst) $fell(done_n));
  cov_ext: cover property (@(posedge clk) disable iff (rst) wr_rise && mode_bit);
  cov_read: cover property (@(posedge clk) disable iff (rst) rd_fall && !done_n);
endmodule : adc_acquisition_sequencer

// file: rtl/adc_seq_pkg.sv
// package: constants and types for the acquisition sequencer
//------------------------------------------------------------
// Behaviour
// - done flag goes low when conversion ends and result is ready
// - read starts on read strobe falling edge with select low; data driven
// - internal mode: write rising edge captures byte, starts acquisition then conversion
// - external mode: first write starts acquisition, a later write with mode bit 0 ends it, starts conversion
// - mode bit 0: track from write edge, hold after 6 conversion clocks
// - mode bit 1: track until a later write with mode bit 0
// - each conversion yields a 12-bit result presented on the bus
// - internal timing at 2 MHz clock sustains 100 ksps
// - conversion lasts 12 conversion clocks in every mode
// - done flag returns high on first read or a new write
// - a write during conversion aborts it and restarts acquisition
// - select high: strobes ignored, data bus released
//------------------------------------------------------------
package adc_seq_pkg;
  localparam int unsigned RESULT_W      = 12;
  localparam int unsigned CFG_W         = 8;
  localparam int unsigned ACQ_MODE_POS  = 5;
  localparam int unsigned RANGE_POS     = 4;
  localparam int unsigned POLARITY_POS  = 3;
  localparam int unsigned PWR_HI_POS    = 7;
  localparam int unsigned PWR_LO_POS    = 6;
  localparam logic [3:0]  ACQ_CYCLES    = 4'h6;
  localparam logic [3:0]  CONV_CYCLES   = 4'hC;
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam logic [1:0]  PWR_MASK_HI   = 2'h3;
  localparam logic [7:0]  CFG_KEEP_MASK = 8'h3F;
  localparam logic [11:0] RESULT_RESET  = 12'h000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ  = 2'b01,
    ST_EXT  = 2'b10,
    ST_CONV = 2'b11
  } seq_state_t;

  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
  } bus_ctl_t;
endpackage : adc_seq_pkg

// file: rtl/adc_result_reg.sv
// result holding register with registered read data
`timescale 1ns/10ps
module adc_result_reg (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // write side
  input  wire logic        load,
  input  wire logic [11:0] load_data,
  // read side
  output logic      [11:0] held
);
  //----------------------------------------
  // storage
  //----------------------------------------
  logic [11:0] next_held;
  always_comb begin
    next_held = held;
    if (load) begin
      next_held = load_data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      held <= adc_seq_pkg::RESULT_RESET;
    end else begin
      held <= next_held;
    end
  end
endmodule : adc_result_reg

// file: dv/adc_core_model.sv
// analog core model: conversion clock ticks and sample value
`timescale 1ns/10ps
module adc_core_model #(
  parameter int unsigned PERIOD = 4
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // value to convert
  input  wire logic [11:0] level,
  // to the sequencer
  output logic             conv_tick,
  output logic      [11:0] sar_result
);
  int unsigned cnt;
  always_ff @(posedge clk) begin
    if (rst || cnt == PERIOD - 1) cnt <= 0;
    else cnt <= cnt + 1;
  end
  assign conv_tick  = (cnt == PERIOD - 1);
  // valid only on a tick, inverted otherwise
  assign sar_result = conv_tick ? level : ~level;
endmodule : adc_core_model

// file: dv/adc_acquisition_sequencer_test.sv
// self-checking bench for the acquisition sequencer
`timescale 1ns/10ps
module adc_acquisition_sequencer_test;
  localparam int unsigned P = 4;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  adc_seq_pkg::bus_ctl_t bus_ctl = 3'b111;
  logic [7:0]            data_in = 8'h00;
  logic [11:0]           level = 12'h0A5C;
  logic [11:0]           data_out;
  logic [11:0]           sar_result;
  logic                  data_oe, conv_tick, done_n, track, converting;
  logic [7:0]            cfg;
  int                    n_errors = 0;
  int                    check_count = 0;
  int                    n;
  always #2 clk = ~clk;
  adc_core_model #(.PERIOD(P)) core (.clk(clk), .rst(rst), .level(level),
    .conv_tick(conv_tick), .sar_result(sar_result));
  adc_acquisition_sequencer dut (.clk(clk), .rst(rst), .bus_ctl(bus_ctl),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .conv_tick(conv_tick), .sar_result(sar_result), .done_n(done_n),
    .track(track), .converting(converting), .cfg(cfg));
  task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    cmp(what, {11'h000, exp}, {11'h000, got});
  endtask : cmp_bit
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic write(input logic [7:0] b, input logic sel_n);
    @(posedge clk);
    bus_ctl <= {sel_n, 1'b0, 1'b1};
    data_in <= b;
    @(posedge clk);
    bus_ctl.wr_n <= 1'b1;
    @(posedge clk);
    bus_ctl.cs_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask : write
  task automatic read(input logic [11:0] exp, input logic sel_n);
    @(posedge clk);
    bus_ctl <= {sel_n, 1'b1, 1'b0};
    repeat (2) @(posedge clk);
    #1;
    cmp_bit("data_oe", !sel_n, data_oe);
    cmp_bit("done_n", !sel_n, done_n);
    if (!sel_n) cmp("data_out", exp, data_out);
    @(posedge clk);
    bus_ctl <= 3'b111;
  endtask : read
  task automatic wait_done(output int cycles);
    cycles = 0;
    while (done_n !== 1'b0) begin
      @(posedge clk);
      #1;
      cycles++;
      if (cycles > 500) begin
        n_errors++;
        $display("[FAIL] done_n expected 0 seen %b", done_n);
        conclude();
      end
    end
  endtask : wait_done
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
    cmp_bit("done_n", 1'b1, done_n);
    cmp_bit("data_oe", 1'b0, data_oe);
    cmp("cfg", 12'h000, {4'h0, cfg});
    $display("test reset done");
    write(8'h18, 1'b0);
    cmp("cfg", 12'h018, {4'h0, cfg});
    cmp_bit("track", 1'b1, track);
    wait_done(n);
    cmp_bit("int_time", 1'b1, n >= 17 * P - 2 && n <= 18 * P + 1);
    cmp_bit("converting", 1'b0, converting);
    read(level, 1'b1);
    read(level, 1'b0);
    $display("test internal done");
    level <= 12'h3A1;
    write(8'h2A, 1'b0);
    repeat (100) @(posedge clk);
    #1;
    cmp_bit("track", 1'b1, track);
    cmp_bit("converting", 1'b0, converting);
    write(8'hFF, 1'b1);
    cmp("cfg", 12'h02A, {4'h0, cfg});
    write(8'h40, 1'b0);
    cmp("cfg", 12'h04A, {4'h0, cfg});
    cmp_bit("converting", 1'b1, converting);
    wait_done(n);
    cmp_bit("ext_time", 1'b1, n >= 11 * P - 2 && n <= 12 * P + 1);
    @(posedge clk);
    #1;
    cmp("data_out", 12'h3A1, data_out);
    $display("test external done");
    write(8'h18, 1'b0);
    cmp_bit("done_n", 1'b1, done_n);
    repeat (8 * P) @(posedge clk);
    #1;
    cmp_bit("converting", 1'b1, converting);
    write(8'h18, 1'b0);
    cmp_bit("converting", 1'b0, converting);
    cmp_bit("track", 1'b1, track);
    wait_done(n);
    cmp_bit("abort_time", 1'b1, n >= 17 * P - 2 && n <= 18 * P + 1);
    read(12'h3A1, 1'b0);
    $display("test abort done");
    conclude();
  end
endmodule : adc_acquisition_sequencer_test
